// File: hdl/serial_port_control.v
`timescale 1ns/100ps
`include "serial_port_regs.vh"
module serial_port_control #(
  parameter POSITIVE_POLARITY = 1'b1
) (
  input wire clk_in,
  input wire nrst_in,
  input wire clk_en_in,
  input wire [15:0] addr_in,
  input wire [3:0] wdata_in,
  input wire write_in,
  input wire read_in,
  output reg [3:0] rdata_out,
  input wire low_speed_oscillator_in,
  input wire serial_input_pin_in,
  input wire serial_clock_pin_in,
  output reg serial_clock_pin_out,
  output wire serial_clock_pin_oe_out,
  output reg serial_output_pin_out,
  output wire serial_output_pin_oe_out,
  output wire slave_ready_pin_out,
  output wire slave_ready_pin_oe_out,
  output wire serial_function_select_out,
  output wire clock_pin_pulldown_out,
  input wire clock_pin_pulldown_reg_in,
  output wire serial_irq_out,
  output wire [7:0] rx_data_out,
  output wire rx_valid_out,
  input wire rx_ready_in
);
  reg [3:0] control_q;
  reg [3:0] format_q;
  reg [7:0] shift_q;
  reg running_q;
  reg [3:0] count_q;
  reg irq_flag_q;
  reg irq_mask_q;
  reg osc_s1_q;
  reg osc_s2_q;
  reg osc_s3_q;
  reg osc_lvl_q;
  reg sck_s1_q;
  reg sck_s2_q;
  reg sck_s3_q;
  reg sck_lvl_q;
  reg sin_s1_q;
  reg sin_s2_q;
  reg sin_s3_q;
  reg sin_lvl_q;
  reg half_q;
  reg [7:0] buf0_q;
  reg [7:0] buf1_q;
  reg [1:0] buf_cnt_q;
  reg int_rise;
  reg int_fall;
  reg [3:0] read_word;

  // Decoded fields of the two setup registers
  wire func_sel = control_q[`CTRL_FUNC_SEL_BIT];
  wire out_en = control_q[`CTRL_OUT_EN_BIT];
  wire [1:0] src = {format_q[`FMT_SRC_HI_BIT], format_q[`FMT_SRC_LO_BIT]};
  wire slave_mode = (src == `SRC_SLAVE);
  wire msb_first = format_q[`FMT_ORDER_BIT];
  wire phase = format_q[`FMT_PHASE_BIT];

  // Register strobes
  wire sel_ctrl = (addr_in == `SERIAL_CONTROL_ADDR);
  wire sel_fmt = (addr_in == `SERIAL_FORMAT_ADDR);
  wire sel_low = (addr_in == `SERIAL_DATA_LOW_ADDR);
  wire sel_high = (addr_in == `SERIAL_DATA_HIGH_ADDR);
  wire sel_flag = (addr_in == `SERIAL_IRQ_FLAG_ADDR);
  wire sel_mask = (addr_in == `SERIAL_IRQ_MASK_ADDR);
  wire wr_ctrl = write_in & sel_ctrl;
  wire wr_fmt = write_in & sel_fmt;
  wire wr_mask = write_in & sel_mask;
  wire clr_flag = write_in & sel_flag & wdata_in[0];

  // Change accepted only when second and third stages agree
  wire osc_agree = (osc_s2_q == osc_s3_q);
  wire osc_rise = osc_agree & osc_s2_q & ~osc_lvl_q;
  wire sck_agree = (sck_s2_q == sck_s3_q);
  wire sck_rise = sck_agree & sck_s2_q & ~sck_lvl_q;
  wire sck_fall = sck_agree & ~sck_s2_q & sck_lvl_q;
  wire sin_now = (sin_s2_q == sin_s3_q) ? sin_s2_q : sin_lvl_q;

  // Internal clock edges come from the synchronised oscillator
  always @* begin
    int_rise = 1'b0;
    int_fall = 1'b0;
    if (src == `SRC_OSC) begin
      int_rise = osc_rise & ~serial_clock_pin_out;
      int_fall = osc_rise & serial_clock_pin_out;
    end else if (src == `SRC_OSC_HALF) begin
      int_rise = osc_rise & half_q & ~serial_clock_pin_out;
      int_fall = osc_rise & half_q & serial_clock_pin_out;
    end
  end

  wire edge_a = slave_mode ? sck_rise : int_rise;
  wire edge_b = slave_mode ? sck_fall : int_fall;
  // Leading edge shifts out, trailing edge samples; phase swaps them
  wire lead = (POSITIVE_POLARITY ^ phase) ? edge_b : edge_a;
  wire trail = (POSITIVE_POLARITY ^ phase) ? edge_a : edge_b;
  wire out_bit = msb_first ? shift_q[7] : shift_q[0];
  wire buf_ready = (buf_cnt_q != 2'h2);
  // A full buffer holds off the next start so no word is lost.
  // Function select comes from the same write, so one access can
  // both hand the pins over and trigger.
  wire start = wr_ctrl & wdata_in[`CTRL_TRIGGER_BIT]
    & wdata_in[`CTRL_FUNC_SEL_BIT] & (src != `SRC_RESERVED)
    & buf_ready & ~running_q;
  wire last = running_q & trail
    & (count_q == `BITS_PER_TRANSFER - 4'h1);

  // Pins and oscillator are asynchronous; the clock pin chain resets
  // to its idle level so no false edge follows reset
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      osc_lvl_q <= 1'b0;
      sck_s1_q <= POSITIVE_POLARITY;
      sck_s2_q <= POSITIVE_POLARITY;
      sck_s3_q <= POSITIVE_POLARITY;
      sck_lvl_q <= POSITIVE_POLARITY;
      sin_s1_q <= 1'b0;
      sin_s2_q <= 1'b0;
      sin_s3_q <= 1'b0;
      sin_lvl_q <= 1'b0;
      half_q <= 1'b0;
    end else if (clk_en_in) begin
      osc_s1_q <= low_speed_oscillator_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      if (osc_agree) begin
        osc_lvl_q <= osc_s2_q;
      end
      sck_s1_q <= serial_clock_pin_in;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      if (sck_agree) begin
        sck_lvl_q <= sck_s2_q;
      end
      sin_s1_q <= serial_input_pin_in;
      sin_s2_q <= sin_s1_q;
      sin_s3_q <= sin_s2_q;
      sin_lvl_q <= sin_now;
      if (osc_rise) begin
        half_q <= ~half_q;
      end
    end
  end

  // Setup registers; format is frozen while a transfer runs
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      control_q <= `CONTROL_RESET;
      format_q <= `FORMAT_RESET;
      irq_mask_q <= 1'b0;
    end else if (clk_en_in) begin
      if (wr_ctrl) begin
        control_q[`CTRL_FUNC_SEL_BIT] <= wdata_in[`CTRL_FUNC_SEL_BIT];
        control_q[`CTRL_OUT_EN_BIT] <= wdata_in[`CTRL_OUT_EN_BIT];
      end
      if (wr_fmt && !running_q) begin
        format_q <= wdata_in;
      end
      if (wr_mask) begin
        irq_mask_q <= wdata_in[0];
      end
    end
  end

  // Set beats clear in the same cycle so no event is dropped
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_flag_q <= 1'b0;
    end else if (clk_en_in) begin
      if (last) begin
        irq_flag_q <= 1'b1;
      end else if (clr_flag) begin
        irq_flag_q <= 1'b0;
      end
    end
  end

  // Transfer engine: bit counter, run status and the two pin drivers
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      running_q <= 1'b0;
      count_q <= 4'h0;
      serial_clock_pin_out <= POSITIVE_POLARITY;
      serial_output_pin_out <= 1'b0;
    end else if (clk_en_in) begin
      if (start) begin
        running_q <= 1'b1;
        count_q <= 4'h0;
        serial_output_pin_out <= out_bit;
      end else if (running_q) begin
        if (!slave_mode && (int_rise || int_fall)) begin
          serial_clock_pin_out <= ~serial_clock_pin_out;
        end
        // First bit already stands from the trigger
        if (lead && count_q != 4'h0) begin
          serial_output_pin_out <= out_bit;
        end
        if (trail) begin
          count_q <= count_q + 4'h1;
        end
        if (last) begin
          running_q <= 1'b0;
        end
      end else begin
        serial_clock_pin_out <= POSITIVE_POLARITY;
      end
    end
  end

  // Data register has no reset: contents undefined until written
  always @(posedge clk_in) begin
    if (clk_en_in) begin
      if (running_q && trail) begin
        if (msb_first) begin
          shift_q <= {shift_q[6:0], sin_now};
        end else begin
          shift_q <= {sin_now, shift_q[7:1]};
        end
      end else if (write_in && !running_q) begin
        if (sel_low) begin
          shift_q[3:0] <= wdata_in;
        end
        if (sel_high) begin
          shift_q[7:4] <= wdata_in;
        end
      end
    end
  end

  // Two-entry receive buffer fed at the end of each transfer
  wire push = last & buf_ready;
  wire pop = rx_valid_out & rx_ready_in;
  wire [7:0] rx_word = msb_first ? {shift_q[6:0], sin_now}
    : {sin_now, shift_q[7:1]};
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      buf0_q <= 8'h00;
      buf1_q <= 8'h00;
      buf_cnt_q <= 2'h0;
    end else if (clk_en_in) begin
      if (pop) begin
        buf0_q <= buf1_q;
        if (push && buf_cnt_q == 2'h1) begin
          buf0_q <= rx_word;
        end else if (push) begin
          buf1_q <= rx_word;
        end
      end else if (push) begin
        if (buf_cnt_q == 2'h0) begin
          buf0_q <= rx_word;
        end else begin
          buf1_q <= rx_word;
        end
      end
      buf_cnt_q <= buf_cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
  assign rx_valid_out = (buf_cnt_q != 2'h0);
  assign rx_data_out = buf0_q;

  // Register view by address
  always @* begin
    read_word = 4'h0;
    case (addr_in)
      `SERIAL_CONTROL_ADDR: begin
        read_word = {1'b0, out_en, running_q, func_sel};
      end
      `SERIAL_FORMAT_ADDR: begin
        read_word = format_q;
      end
      `SERIAL_DATA_LOW_ADDR: begin
        read_word = shift_q[3:0];
      end
      `SERIAL_DATA_HIGH_ADDR: begin
        read_word = shift_q[7:4];
      end
      `SERIAL_IRQ_FLAG_ADDR: begin
        read_word = {3'h0, irq_flag_q};
      end
      `SERIAL_IRQ_MASK_ADDR: begin
        read_word = {3'h0, irq_mask_q};
      end
      default: begin
        read_word = 4'h0;
      end
    endcase
  end

  // Zero outside a read so several units can share the read bus
  always @* begin
    rdata_out = 4'h0;
    if (read_in) begin
      rdata_out = read_word;
    end
  end

  // Pin control for the shared port pins
  assign serial_function_select_out = func_sel;
  assign serial_output_pin_oe_out = func_sel & out_en;
  assign serial_clock_pin_oe_out = func_sel & ~slave_mode;
  // Slave ready is low-active: low while the port waits for clocks
  assign slave_ready_pin_out = ~running_q;
  assign slave_ready_pin_oe_out = func_sel & slave_mode;
  assign clock_pin_pulldown_out = func_sel & slave_mode
    & clock_pin_pulldown_reg_in;
  assign serial_irq_out = irq_flag_q & irq_mask_q;
endmodule

// File: hdl/serial_port_regs.vh
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH
`define SERIAL_CONTROL_ADDR 16'hFF70
`define SERIAL_FORMAT_ADDR 16'hFF71
`define SERIAL_DATA_LOW_ADDR 16'hFF72
`define SERIAL_DATA_HIGH_ADDR 16'hFF73
`define SERIAL_IRQ_FLAG_ADDR 16'hFFF2
`define SERIAL_IRQ_MASK_ADDR 16'hFFE2
`define CTRL_FUNC_SEL_BIT 0
`define CTRL_TRIGGER_BIT 1
`define CTRL_OUT_EN_BIT 2
`define FMT_SRC_LO_BIT 0
`define FMT_SRC_HI_BIT 1
`define FMT_PHASE_BIT 2
`define FMT_ORDER_BIT 3
`define CONTROL_RESET 4'h0
`define FORMAT_RESET 4'h0
`define SRC_SLAVE 2'h0
`define SRC_RESERVED 2'h1
`define SRC_OSC_HALF 2'h2
`define SRC_OSC 2'h3
`define BITS_PER_TRANSFER 4'h8
`endif

// File: testbench/serial_peer.sv
`timescale 1ns/100ps
module serial_peer (
  input wire sclk_in,
  input wire sdo_in,
  input wire load_in,
  input wire [7:0] word_in,
  output reg sdi_out,
  output reg [7:0] rx_word_out
);
  reg [7:0] sh;
  reg [3:0] n;
  initial sdi_out = 1'h0;
  always @(posedge load_in) begin
    sh = word_in;
    n = 4'h0;
    sdi_out = word_in[7];
  end
  // Device shifts out on the falling edge and samples on the rising one
  always @(sclk_in) begin
    if (sclk_in) begin
      rx_word_out <= {rx_word_out[6:0], sdo_in};
      sh <= {sh[6:0], 1'h0};
      n <= n + 4'h1;
      // Inverted after last bit, so no stale level
      if (n == 4'h7) sdi_out <= ~sdi_out;
    end else if (n != 4'h0) begin
      sdi_out <= sh[7];
    end
  end
endmodule

// File: testbench/spc_sva.sv
`timescale 1ns/100ps
module spc_sva (
  input wire clk_in,
  input wire nrst_in,
  input wire [15:0] addr_in,
  input wire read_in,
  input wire [3:0] rdata_out,
  input wire serial_clock_pin_out,
  input wire serial_clock_pin_oe_out,
  input wire serial_output_pin_oe_out,
  input wire slave_ready_pin_out,
  input wire slave_ready_pin_oe_out,
  input wire serial_function_select_out,
  input wire clock_pin_pulldown_out,
  input wire clock_pin_pulldown_reg_in,
  input wire [7:0] rx_data_out,
  input wire rx_valid_out,
  input wire rx_ready_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire sel = serial_function_select_out;
  property p_oe; serial_output_pin_oe_out |-> sel; endproperty
  a_oe: assert property (p_oe) else $error("data pin driven");
  property p_cke; serial_clock_pin_oe_out |-> sel; endproperty
  a_cke: assert property (p_cke) else $error("clock pin driven");
  property p_pd; clock_pin_pulldown_out == (sel && slave_ready_pin_oe_out
    && clock_pin_pulldown_reg_in); endproperty
  a_pd: assert property (p_pd) else $error("pull-down wrong");
  property p_ctl; read_in && addr_in == 16'hFF70 |-> rdata_out[3] == 1'h0
    && rdata_out[1] == !slave_ready_pin_out; endproperty
  a_ctl: assert property (p_ctl) else $error("status wrong");
  property p_flg; read_in && addr_in == 16'hFFF2 |-> rdata_out[3:1] == 3'h0;
  endproperty
  a_flg: assert property (p_flg) else $error("flag bits wrong");
  property p_idle; slave_ready_pin_out [*2] |-> $stable(serial_clock_pin_out);
  endproperty
  a_idle: assert property (p_idle) else $error("clock moved idle");
  property p_rx; rx_valid_out && !rx_ready_in |=> rx_valid_out
    && $stable(rx_data_out); endproperty
  a_rx: assert property (p_rx) else $error("stalled word lost");
  property p_slv; slave_ready_pin_oe_out |-> sel && !serial_clock_pin_oe_out;
  endproperty
  a_slv: assert property (p_slv) else $error("slave drives clock");
  c_run: cover property ($fell(slave_ready_pin_out));
  c_stall: cover property (rx_valid_out && !rx_ready_in);
  c_oe: cover property (serial_output_pin_oe_out);
endmodule

// File: testbench/test_clocked_serial_port_control.sv
`timescale 1ns/100ps
`include "serial_port_regs.vh"
module test_clocked_serial_port_control;
  reg clk_in = 1'h0, nrst_in = 1'h0, wr_en = 1'h0, rd_en = 1'h0, osc = 1'h0;
  reg rx_rdy = 1'h0, pd = 1'h1, load = 1'h0;
  reg [15:0] addr = 16'h0000;
  reg [3:0] wd = 4'h0;
  reg [7:0] word = 8'h00;
  wire [3:0] rdata;
  wire [7:0] rx_data, peer_rx;
  wire sclk, sdo, sdi, sel, rx_valid, sdo_oe, rdy, irq;
  integer miscompares = 0, comparisons = 0;
  serial_port_control i_dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .clk_en_in(1'h1), .addr_in(addr), .wdata_in(wd), .write_in(wr_en),
    .read_in(rd_en), .rdata_out(rdata), .low_speed_oscillator_in(osc),
    .serial_input_pin_in(sdi), .serial_clock_pin_in(sclk),
    .serial_clock_pin_out(sclk), .serial_clock_pin_oe_out(),
    .serial_output_pin_out(sdo), .serial_output_pin_oe_out(sdo_oe),
    .slave_ready_pin_out(rdy), .slave_ready_pin_oe_out(),
    .serial_function_select_out(sel), .clock_pin_pulldown_out(),
    .clock_pin_pulldown_reg_in(pd), .serial_irq_out(irq),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_ready_in(rx_rdy));
  serial_peer i_peer (.sclk_in(sclk), .sdo_in(sdo), .load_in(load),
    .word_in(word), .sdi_out(sdi), .rx_word_out(peer_rx));
  initial forever #20 clk_in = ~clk_in;
  initial forever #160 osc = ~osc;
  function [7:0] rev(input [7:0] x);
    rev = {x[0], x[1], x[2], x[3], x[4], x[5], x[6], x[7]};
  endfunction
  task chk(input [7:0] s, input [7:0] e, input [63:0] nm);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("wrong value %0s: expected %h, seen %h", nm, e, s);
      end
    end
  endtask
  task wr(input [15:0] a, input [3:0] d);
    begin
      @(negedge clk_in);
      addr = a;
      wd = d;
      wr_en = 1'h1;
      @(negedge clk_in);
      wr_en = 1'h0;
    end
  endtask
  task rc(input [15:0] a, input [3:0] e, input [63:0] nm);
    begin
      @(negedge clk_in);
      addr = a;
      rd_en = 1'h1;
      @(negedge clk_in);
      chk(rdata, e, nm);
      rd_en = 1'h0;
    end
  endtask
  task t_reset;
    begin
      rc(`SERIAL_CONTROL_ADDR, 4'h0, "ctrl");
      rc(`SERIAL_FORMAT_ADDR, 4'h0, "format");
      rc(`SERIAL_IRQ_FLAG_ADDR, 4'h0, "flag");
      chk(sel, 1'h0, "funcsel");
    end
  endtask
  task t_refuse;
    begin
      wr(`SERIAL_FORMAT_ADDR, 4'h1);
      wr(`SERIAL_CONTROL_ADDR, 4'h3);
      rc(`SERIAL_CONTROL_ADDR, 4'h1, "reserved");
      wr(`SERIAL_FORMAT_ADDR, 4'h3);
      wr(`SERIAL_CONTROL_ADDR, 4'h2);
      rc(`SERIAL_CONTROL_ADDR, 4'h0, "nofunc");
    end
  endtask
  task t_xfer(input o, input en, input [1:0] s, input [7:0] d,
    input [7:0] p);
    integer i;
    begin
      word = p;
      load = 1'h1;
      wr(`SERIAL_DATA_LOW_ADDR, d[3:0]);
      wr(`SERIAL_DATA_HIGH_ADDR, d[7:4]);
      rc(`SERIAL_DATA_HIGH_ADDR, d[7:4], "datahi");
      wr(`SERIAL_FORMAT_ADDR, {o, 1'h0, s});
      wr(`SERIAL_CONTROL_ADDR, {1'h0, en, 2'h3});
      load = 1'h0;
      rc(`SERIAL_CONTROL_ADDR, {1'h0, en, 2'h3}, "running");
      chk(sdo_oe, en, "out_oe");
      i = 0;
      while (rdy !== 1'h1 && i < 400) begin
        @(negedge clk_in);
        i = i + 1;
      end
      chk(i < 400, 1'h1, "done");
      rc(`SERIAL_CONTROL_ADDR, {1'h0, en, 2'h1}, "stopped");
      rc(`SERIAL_IRQ_FLAG_ADDR, 4'h1, "flagset");
      chk(peer_rx, o ? d : rev(d), "peer_rx");
    end
  endtask
  task t_irq;
    begin
      wr(`SERIAL_IRQ_MASK_ADDR, 4'h1);
      chk(irq, 1'h1, "irq_on");
      wr(`SERIAL_IRQ_FLAG_ADDR, 4'h1);
      chk(irq, 1'h0, "irq_off");
      wr(`SERIAL_IRQ_MASK_ADDR, 4'h0);
    end
  endtask
  task t_full;
    begin
      // Two stalled words fill the buffer, so trigger is refused
      wr(`SERIAL_CONTROL_ADDR, 4'h3);
      rc(`SERIAL_CONTROL_ADDR, 4'h1, "full");
      chk(rx_data, rev(8'h3C), "word1");
      @(negedge clk_in);
      rx_rdy = 1'h1;
      @(negedge clk_in);
      chk(rx_data, 8'hC1, "word2");
      @(negedge clk_in);
      rx_rdy = 1'h0;
      chk(rx_valid, 1'h0, "empty");
    end
  endtask
  task summarize;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    #200000;
    miscompares = miscompares + 1;
    summarize;
  end
  initial begin
    repeat (16) @(negedge clk_in);
    nrst_in = 1'h1;
    t_reset;
    t_refuse;
    t_xfer(1'h0, 1'h1, 2'h3, 8'hA5, 8'h3C);
    t_irq;
    t_xfer(1'h1, 1'h0, 2'h2, 8'h96, 8'hC1);
    t_full;
    summarize;
  end
endmodule
bind serial_port_control spc_sva i_sva (.clk_in(clk_in),
  .nrst_in(nrst_in), .addr_in(addr_in), .read_in(read_in),
  .rdata_out(rdata_out), .serial_clock_pin_out(serial_clock_pin_out),
  .serial_clock_pin_oe_out(serial_clock_pin_oe_out),
  .serial_output_pin_oe_out(serial_output_pin_oe_out),
  .slave_ready_pin_out(slave_ready_pin_out),
  .slave_ready_pin_oe_out(slave_ready_pin_oe_out),
  .serial_function_select_out(serial_function_select_out),
  .clock_pin_pulldown_out(clock_pin_pulldown_out),
  .clock_pin_pulldown_reg_in(clock_pin_pulldown_reg_in),
  .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out),
  .rx_ready_in(rx_ready_in));
